// File: src/p0io_pkg.sv
/*
 * p0io_pkg: constants shared by the port 0 block: special function space
 * window, register offsets, reset values and widths.
 * Assumes the CPU bus presents a 16-bit byte address and 8-bit data.
 */
`default_nettype none
package p0io_pkg;
	localparam int          ADDR_W       = 16;
	localparam int          DATA_W       = 8;
	localparam int          OFS_W        = 6;
	// special function space spans 0000H..003FH
	localparam logic [15:0] SFS_BASE     = 16'h0000;
	localparam logic [15:0] SFS_LAST     = 16'h003F;
	localparam logic [5:0]  OFS_LATCH    = 6'h00;
	localparam logic [5:0]  OFS_DRIVE    = 6'h0B;
	localparam logic [5:0]  OFS_PINLVL   = 6'h0C;
	localparam logic [7:0]  LATCH_RESET  = 8'hFF;
	localparam logic [7:0]  DRIVE_RESET  = 8'h00;
	localparam logic [7:0]  RDATA_IDLE   = 8'h00;
	localparam int          SYNC_STAGES  = 2;
endpackage
`default_nettype wire

// File: src/p0io_sync.sv
/*
 * p0io_sync: two-stage synchroniser for a vector of levels.
 * Assumes rst_n is asynchronous; flops take RESET_VAL while it is low.
 */
`timescale 1ns/1ns
`default_nettype none
module p0io_sync #(
	parameter int             WIDTH     = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} p0io_sync_s;

	p0io_sync_s state_reg;
	p0io_sync_s state_next;

	always_comb begin
		state_next        = state_reg;
		state_next.meta   = din;
		// first stage feeds only the second stage
		state_next.stable = state_reg.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= {RESET_VAL, RESET_VAL};
		end else begin
			state_reg <= state_next;
		end
	end

	assign dout = state_reg.stable;
endmodule // p0io_sync
`default_nettype wire

// File: src/p0io_top.sv
/*
 * p0io_top: 8-bit bidirectional port 0 with output latch, drive type
 * select and pin level read, reached through the special function space.
 * Assumes a single-cycle CPU strobe per access on CLK, alternate function
 * units on the same clock, and an external pad that resolves O/OE.
 */
// Overview of operation
// - decode registers inside 0000H..003FH window only
// - output latch holds value until rewritten
// - pin level sampled in read state one
// - pin output changes in write state two
// - eight-bit port shared with peripheral functions
// - general output drives latch onto pin
// - reset sets latch ones, drive select zeros
// - drive bit zero open-drain, one push-pull
// - latch register read returns stored latch
// - read-only pin level register at 000CH
`timescale 1ns/1ns
`default_nettype none
module p0io_top #(
	parameter int WIDTH = 8
) (
	input  wire logic                          CLK,
	input  wire logic                          ARST_N,
	input  wire logic [p0io_pkg::ADDR_W-1:0]   ADDR,
	input  wire logic                          RD_STB,
	input  wire logic                          WR_STB,
	input  wire logic [p0io_pkg::DATA_W-1:0]   WDATA,
	output logic      [p0io_pkg::DATA_W-1:0]   RDATA,
	output logic                               RVALID,
	input  wire logic [WIDTH-1:0]              ALT_OUT,
	input  wire logic [WIDTH-1:0]              ALT_EN,
	output logic      [WIDTH-1:0]              PIN_LEVEL,
	input  wire logic [WIDTH-1:0]              P0_I,
	output logic      [WIDTH-1:0]              P0_O,
	output logic      [WIDTH-1:0]              P0_OE
);
	typedef struct packed {
		logic [WIDTH-1:0]            latch;
		logic [WIDTH-1:0]            drive;
		logic [p0io_pkg::DATA_W-1:0] rdata;
		logic                        rvalid;
		logic [WIDTH-1:0]            pin_o;
		logic [WIDTH-1:0]            pin_oe;
	} p0io_state_s;

	typedef enum logic [1:0] {
		P0IO_SEL_NONE   = 2'b00,
		P0IO_SEL_LATCH  = 2'b01,
		P0IO_SEL_DRIVE  = 2'b10,
		P0IO_SEL_PINLVL = 2'b11
	} p0io_sel_e;

	logic                    rst_n;
	logic        [WIDTH-1:0] pin_sync;
	p0io_state_s             state_reg;
	p0io_state_s             state_next;
	p0io_sel_e               sel;
	logic        [WIDTH-1:0] level;

	// release of the async reset is retimed so all flops leave reset together
	p0io_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'b0)
	) u_rst_sync (
		.clk   (CLK),
		.rst_n (ARST_N),
		.din   (1'b1),
		.dout  (rst_n)
	);

	// pins come from outside the clock domain
	p0io_sync #(
		.WIDTH     (WIDTH),
		.RESET_VAL ({WIDTH{1'b1}})
	) u_pin_sync (
		.clk   (CLK),
		.rst_n (rst_n),
		.din   (P0_I),
		.dout  (pin_sync)
	);

	// full 16-bit compare so aliases outside the window never hit
	function automatic p0io_sel_e decode(input logic [p0io_pkg::ADDR_W-1:0] a);
		logic [p0io_pkg::OFS_W-1:0] ofs;
		ofs = a[p0io_pkg::OFS_W-1:0];
		decode = P0IO_SEL_NONE;
		if (a >= p0io_pkg::SFS_BASE && a <= p0io_pkg::SFS_LAST) begin
			case (ofs)
				p0io_pkg::OFS_LATCH:  decode = P0IO_SEL_LATCH;
				p0io_pkg::OFS_DRIVE:  decode = P0IO_SEL_DRIVE;
				p0io_pkg::OFS_PINLVL: decode = P0IO_SEL_PINLVL;
				default:              decode = P0IO_SEL_NONE;
			endcase
		end
	endfunction

	assign sel = decode(ADDR);

	// drive value per bit: alternate unit can only pull a latch of one low
	function automatic logic [WIDTH-1:0] out_value(input logic [WIDTH-1:0] lat,
	                                               input logic [WIDTH-1:0] aen,
	                                               input logic [WIDTH-1:0] aout);
		out_value = lat & (~aen | aout);
	endfunction

	always_comb begin
		state_next        = state_reg;
		state_next.rvalid = 1'b0;
		level             = '0;
		// write taken at the end of state one; pins move in state two
		if (WR_STB) begin
			case (sel)
				P0IO_SEL_LATCH:  state_next.latch = WDATA[WIDTH-1:0];
				P0IO_SEL_DRIVE:  state_next.drive = WDATA[WIDTH-1:0];
				default:         state_next.latch = state_reg.latch;
			endcase
		end
		if (RD_STB) begin
			state_next.rvalid = 1'b1;
			case (sel)
				P0IO_SEL_LATCH:  state_next.rdata = {{(p0io_pkg::DATA_W-WIDTH){1'b0}},
				                                    state_reg.latch};
				P0IO_SEL_DRIVE:  state_next.rdata = {{(p0io_pkg::DATA_W-WIDTH){1'b0}},
				                                    state_reg.drive};
				// pin level taken in the strobe cycle, i.e. read state one
				P0IO_SEL_PINLVL: state_next.rdata = {{(p0io_pkg::DATA_W-WIDTH){1'b0}},
				                                    pin_sync};
				default:         state_next.rdata = p0io_pkg::RDATA_IDLE;
			endcase
		end
		level = out_value(state_next.latch, ALT_EN, ALT_OUT);
		for (int i = 0; i < WIDTH; i++) begin
			if (state_next.drive[i]) begin
				state_next.pin_o[i]  = level[i];
				state_next.pin_oe[i] = 1'b1;
			end else begin
				// open drain: one floats, zero sinks
				state_next.pin_o[i]  = 1'b0;
				state_next.pin_oe[i] = ~level[i];
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.latch  <= p0io_pkg::LATCH_RESET[WIDTH-1:0];
			state_reg.drive  <= p0io_pkg::DRIVE_RESET[WIDTH-1:0];
			state_reg.rdata  <= p0io_pkg::RDATA_IDLE;
			state_reg.rvalid <= 1'b0;
			state_reg.pin_o  <= '0;
			state_reg.pin_oe <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign RDATA     = state_reg.rdata;
	assign RVALID    = state_reg.rvalid;
	assign P0_O      = state_reg.pin_o;
	assign P0_OE     = state_reg.pin_oe;
	// synchronised levels for interrupt, serial, uart and timer inputs
	assign PIN_LEVEL = pin_sync;
endmodule // p0io_top
`default_nettype wire

// File: dv/p0io_pad_model.sv
/* p0io_pad_model: board side of the eight port 0 pads.
   Assumes a pull-up on every pin and an optional external driver per bit. */
`timescale 1ns/1ns
`default_nettype none
module p0io_pad_model (
	input  wire logic [7:0] o,
	input  wire logic [7:0] oe,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin
);
	// pad drive wins a fight; an undriven pin floats up to one
	assign pin = (oe & o) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
endmodule // p0io_pad_model
`default_nettype wire

// File: dv/p0io_asserts.sv
/* p0io_asserts: port-level checks of the port 0 block.
   Assumes it is bound into p0io_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module p0io_asserts #(
	parameter int WIDTH = 8
) (
	input wire logic             CLK,
	input wire logic             ARST_N,
	input wire logic [15:0]      ADDR,
	input wire logic             RD_STB,
	input wire logic             WR_STB,
	input wire logic [7:0]       WDATA,
	input wire logic [7:0]       RDATA,
	input wire logic             RVALID,
	input wire logic [WIDTH-1:0] ALT_OUT,
	input wire logic [WIDTH-1:0] ALT_EN,
	input wire logic [WIDTH-1:0] PIN_LEVEL,
	input wire logic [WIDTH-1:0] P0_I,
	input wire logic [WIDTH-1:0] P0_O,
	input wire logic [WIDTH-1:0] P0_OE
);
	logic [7:0] eff;
	// level a pull-up pin shows, whichever output stage is chosen
	assign eff = P0_O | ~P0_OE;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_latch_wr; WR_STB && ADDR == 16'h0000; endsequence
	sequence s_latch_rd; RD_STB && !WR_STB && ADDR == 16'h0000; endsequence
	a_read_answers: assert property (RD_STB |=> RVALID)
		else $error("read got no answer");
	a_answer_cause: assert property (RVALID |-> $past(RD_STB))
		else $error("answer without read");
	a_window_decode: assert property (RD_STB && ADDR > 16'h003F |=> RDATA == 8'h00)
		else $error("read outside window not zero");
	a_od_no_high: assert property ((P0_O & ~P0_OE) == 8'h00)
		else $error("undriven pin shows high output");
	a_latch_readback: assert property (s_latch_wr ##1 !WR_STB ##1 s_latch_rd |=> RDATA == $past(WDATA, 3))
		else $error("latch read differs from write");
	a_write_to_pin: assert property (WR_STB && ADDR == 16'h0000 && ALT_EN == 8'h00 |=> eff == $past(WDATA))
		else $error("pins not updated after write");
	a_latch_holds: assert property (!(WR_STB && ADDR == 16'h0000) && $stable(ALT_EN) && $stable(ALT_OUT) |=> $stable(eff))
		else $error("pins moved without write");
	a_pin_read: assert property ($stable(P0_I)[*5] ##0 RD_STB && ADDR == 16'h000C |=> RDATA == $past(P0_I))
		else $error("pin level read wrong");
	a_reset_state: assert property ($rose(ARST_N) |-> eff == 8'hFF && P0_OE == 8'h00)
		else $error("reset pin state wrong");
	a_drive_select: assert property (WR_STB && ADDR == 16'h000B |=> (P0_OE & $past(WDATA)) == $past(WDATA) && (P0_O & ~$past(WDATA)) == 8'h00)
		else $error("output stage select wrong");
endmodule // p0io_asserts
`default_nettype wire

// File: dv/p0io_top_tb.sv
/* p0io_top_tb: register-level tests of the port 0 block.
   Assumes the pad model closes the pin loop; checker bound below. */
`timescale 1ns/1ns
`default_nettype none
module p0io_top_tb;
	logic        CLK, ARST_N, RD_STB, WR_STB, RVALID;
	logic [15:0] ADDR;
	logic [7:0]  WDATA, RDATA, ALT_OUT, ALT_EN, PIN_LEVEL, P0_I, P0_O, P0_OE, ext_en, ext_val;
	int          mismatches = 0, samples_checked = 0, cycles = 0;
	p0io_top u_p0io_top (.*);
	p0io_pad_model u_p0io_pad_model (.o(P0_O), .oe(P0_OE), .ext_en(ext_en), .ext_val(ext_val), .pin(P0_I));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR_STB <= 1'h1;
		@(posedge CLK);
		WR_STB <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD_STB <= 1'h1;
		@(posedge CLK);
		RD_STB <= 1'h0;
		#1 chk("rvalid", 8'h01, {7'h00, RVALID});
		chk("rdata", e, RDATA);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		CLK = 1'h0;
		forever #10 CLK = ~CLK;
	end
	// whole sequence needs well under a thousand cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		{ARST_N, RD_STB, WR_STB, ADDR, WDATA, ALT_OUT, ALT_EN, ext_en, ext_val} = '0;
		repeat (12) @(posedge CLK);
		ARST_N <= 1'h1;
		repeat (3) @(posedge CLK);
		rd(16'h0000, 8'hFF);
		rd(16'h000B, 8'h00);
		rd(16'h000C, 8'hFF);
		wr(16'h0000, 8'hA5);
		#1 chk("pins", 8'hA5, P0_O | ~P0_OE);
		rd(16'h0000, 8'hA5);
		repeat (3) @(posedge CLK);
		rd(16'h000C, 8'hA5);
		ext_en <= 8'hFF;
		repeat (4) @(posedge CLK);
		rd(16'h000C, 8'h00);
		chk("pin_level", 8'h00, PIN_LEVEL);
		rd(16'h0000, 8'hA5);
		wr(16'h000B, 8'hFF);
		#1 chk("oe", 8'hFF, P0_OE);
		chk("out", 8'hA5, P0_O);
		repeat (4) @(posedge CLK);
		rd(16'h000C, 8'hA5);
		wr(16'h000C, 8'h00);
		wr(16'h0040, 8'h00);
		rd(16'h0000, 8'hA5);
		rd(16'h000B, 8'hFF);
		rd(16'h0040, 8'h00);
		rd(16'h0001, 8'h00);
		ALT_EN <= 8'h01;
		repeat (2) @(posedge CLK);
		#1 chk("alt", 8'hA4, P0_O);
		@(posedge CLK);
		ALT_EN <= 8'h00;
		ARST_N <= 1'h0;
		@(posedge CLK);
		#1 chk("oe_rst", 8'h00, P0_OE);
		@(posedge CLK);
		ARST_N <= 1'h1;
		repeat (3) @(posedge CLK);
		rd(16'h0000, 8'hFF);
		stop_test();
	end
endmodule // p0io_top_tb
bind p0io_top p0io_asserts #(.WIDTH(WIDTH)) u_p0io_asserts (.*);
`default_nettype wire
